/* dv/pin_load.sv */
// load model on the two compare output pins
`timescale 1ns/1ps
module pin_load (
  input wire logic pclk,
  input wire logic presetn,
  input wire timer_pkg::pin_drive_t drive,
  output logic [1:0] pin_level
);
  logic [1:0] last_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // no pull on the line: a released pin flips every cycle so a stale value never matches
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin_level[i] = drive.pin_oe[i] ? drive.pin_out[i] : ~last_ff[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ff <= 2'h0;
    end else begin
      last_ff <= pin_level;
    end
  end
endmodule

/* dv/testbench.sv */
// self-checking bench for the compare/waveform timer
`timescale 1ns/1ps
module testbench;
  logic pclk;
  logic presetn;
  timer_pkg::apb_req_t req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] pin_level;
  timer_pkg::pin_drive_t drive;
  int err_total;
  int total_checks;
  logic [31:0] rv;
  logic re;
  int hi;
  int per;
  int lo_cnt;

  assign drive = {pin_out, pin_oe};

  timer_compare #(.CHANNELS(2)) i_timer_compare (.pclk(pclk), .presetn(presetn), .psel(req.psel),
    .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_load i_pin_load (.pclk(pclk), .presetn(presetn), .drive(drive), .pin_level(pin_level));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ctl(input logic [2:0] w, input logic [2:0] s, input logic [1:0] a,
                                      input logic [1:0] b);
    return {20'h0, b, a, 1'b0, s, 1'b0, w};
  endfunction

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no local limit: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rv, re);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi_lim);
    total_checks++;
    if ((got >= lo && got <= hi_lim) !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi_lim);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, rv, re);
    chk(rv, exp);
  endtask

  // high time and period of one pin, in pclk cycles, sampled where settled
  task automatic measure(input int ch, output int h, output int p);
    int n;
    n = 0;
    h = 0;
    while (pin_level[ch] !== 1'b0 && n < 2000) begin @(negedge pclk); n++; end
    while (pin_level[ch] !== 1'b1 && n < 2000) begin @(negedge pclk); n++; end
    while (pin_level[ch] === 1'b1 && n < 2000) begin @(negedge pclk); n++; h++; end
    p = h;
    while (pin_level[ch] !== 1'b1 && n < 2000) begin @(negedge pclk); n++; p++; end
  endtask

  // stop the timer, then load compare A and the count
  task automatic setup(input logic [7:0] cmp_a, input logic [7:0] cnt);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    wr(timer_pkg::OFF_CMP_A, {24'h0, cmp_a});
    wr(timer_pkg::OFF_COUNT, {24'h0, cnt});
    wr(timer_pkg::OFF_FLAGS, 32'h7);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // whole run is well under 15k cycles
  initial begin
    repeat (40000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    err_total = 0;
    total_checks = 0;
    req = '0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      if (i != 5) rdchk(8'(4 * i), 32'h0);
    end
    xfer(1'b0, 8'h1c, 32'h0, rv, re);
    chk({31'h0, re}, 32'h1);
    chk(rv, 32'h0);
    $display("test reset done");

    setup(8'h00, 8'h55);
    wr(timer_pkg::OFF_CTRL, ctl(3'h0, 3'h0, timer_pkg::OMODE_SET, 2'h0));
    wr(timer_pkg::OFF_FORCE, 32'h1);
    rdchk(timer_pkg::OFF_PIN, 32'h100);
    chk({30'h0, pin_oe}, 32'h0);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    wr(timer_pkg::OFF_FORCE, 32'h1);
    rdchk(timer_pkg::OFF_PIN, 32'h100);
    wr(timer_pkg::OFF_CTRL, ctl(3'h0, 3'h0, timer_pkg::OMODE_TOGGLE, 2'h0));
    wr(timer_pkg::OFF_FORCE, 32'h1);
    rdchk(timer_pkg::OFF_PIN, 32'h000);
    wr(timer_pkg::OFF_FORCE, 32'h1);
    rdchk(timer_pkg::OFF_FLAGS, 32'h0);
    rdchk(timer_pkg::OFF_COUNT, 32'h55);
    wr(timer_pkg::OFF_PIN, 32'h10);
    repeat (2) @(negedge pclk);
    // channel b is released here, so its line level flips every cycle
    chk({31'h0, pin_level[0]}, 32'h1);
    chk({30'h0, pin_oe}, 32'h1);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    repeat (2) @(negedge pclk);
    chk({31'h0, pin_level[0]}, 32'h0);
    $display("test force and override done");

    setup(8'h00, 8'h00);
    wr(timer_pkg::OFF_CTRL, ctl(3'h0, 3'h2, 2'h0, 2'h0));
    repeat (80) @(posedge pclk);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    xfer(1'b0, timer_pkg::OFF_COUNT, 32'h0, rv, re);
    chk_in(rv, 32'd9, 32'd11);
    wr(timer_pkg::OFF_COUNT, 32'h20);
    repeat (50) @(posedge pclk);
    rdchk(timer_pkg::OFF_COUNT, 32'h20);
    $display("test prescale done");

    setup(8'h00, 8'h10);
    wr(timer_pkg::OFF_CMP_A, 32'h80);
    wr(timer_pkg::OFF_CTRL, ctl(3'h0, 3'h1, 2'h0, 2'h0));
    repeat (5) @(posedge pclk);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    rdchk(timer_pkg::OFF_FLAGS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) wr(timer_pkg::OFF_COUNT, 32'hfa);
      wr(timer_pkg::OFF_CTRL, ctl(3'h0, 3'h1, 2'h0, 2'h0));
      repeat (10) @(posedge pclk);
      wr(timer_pkg::OFF_CTRL, 32'h0);
      rdchk(timer_pkg::OFF_FLAGS, 32'h5);
    end
    xfer(1'b0, timer_pkg::OFF_COUNT, 32'h0, rv, re);
    chk_in(rv, 32'h0a, 32'h18);
    $display("test normal done");

    setup(8'h03, 8'h00);
    wr(timer_pkg::OFF_PIN, 32'h10);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::WAVE_CLEAR_ON_MATCH, 3'h1, timer_pkg::OMODE_TOGGLE, 2'h0));
    measure(0, hi, per);
    chk(hi, 32'd4);
    chk(per, 32'd8);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, timer_pkg::OFF_COUNT, 32'h0, rv, re);
      chk_in(rv, 32'h0, 32'h3);
    end
    rdchk(timer_pkg::OFF_FLAGS, 32'h6);
    setup(8'h80, 8'h90);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::WAVE_CLEAR_ON_MATCH, 3'h1, 2'h0, 2'h0));
    repeat (20) @(posedge pclk);
    xfer(1'b0, timer_pkg::OFF_COUNT, 32'h0, rv, re);
    chk_in(rv, 32'h98, 32'hb0);
    repeat (120) @(posedge pclk);
    wr(timer_pkg::OFF_CTRL, 32'h0);
    rdchk(timer_pkg::OFF_FLAGS, 32'h5);
    xfer(1'b0, timer_pkg::OFF_COUNT, 32'h0, rv, re);
    chk_in(rv, 32'h10, 32'h40);
    $display("test clear on match done");

    setup(8'h40, 8'h00);
    wr(timer_pkg::OFF_PIN, 32'h30);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::WAVE_FAST_MAX, 3'h1, timer_pkg::OMODE_CLEAR, timer_pkg::OMODE_CLEAR));
    measure(0, hi, per);
    chk_in(hi, 32'h40, 32'h41);
    chk(per, 32'd256);
    measure(1, hi, per);
    chk_in(hi, 32'd1, 32'd2);
    chk(per, 32'd256);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::WAVE_FAST_MAX, 3'h1, timer_pkg::OMODE_SET, timer_pkg::OMODE_CLEAR));
    wr(timer_pkg::OFF_FLAGS, 32'h7);
    repeat (300) @(posedge pclk);
    measure(0, hi, per);
    chk_in(hi, 32'hbf, 32'hc0);
    chk(per, 32'd256);
    rdchk(timer_pkg::OFF_FLAGS, 32'h7);
    // compare at max: buffered value lands at top, then the level must stay high
    wr(timer_pkg::OFF_CMP_A, 32'hff);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::WAVE_FAST_MAX, 3'h1, timer_pkg::OMODE_CLEAR, timer_pkg::OMODE_CLEAR));
    repeat (600) @(posedge pclk);
    lo_cnt = 0;
    repeat (300) begin
      @(negedge pclk);
      if (pin_level[0] !== 1'b1) begin
        lo_cnt++;
      end
    end
    chk(lo_cnt, 32'd0);
    setup(8'h1f, 8'h00);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::WAVE_FAST_CMP, 3'h1, timer_pkg::OMODE_TOGGLE, 2'h0));
    measure(0, hi, per);
    chk(hi, 32'd32);
    chk(per, 32'd64);
    $display("test fast pwm done");
    tally_and_finish();
  end
endmodule

/* inc/timer_pkg.sv */
// shared constants and types for the 8-bit compare/waveform timer
package timer_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_CMP_A = 8'h08;
  localparam logic [7:0] OFF_CMP_B = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_FORCE = 8'h14;
  localparam logic [7:0] OFF_PIN = 8'h18;

  // control word field positions
  localparam int CTRL_WAVE_LSB = 0;
  localparam int CTRL_CLKSEL_LSB = 4;
  localparam int CTRL_OMODE_LSB = 8;
  // flag word bit positions, match flags follow overflow
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_MATCH_LSB = 1;
  // pin word: port data in bits 1:0, direction in 5:4, output state in 9:8
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_DIR_LSB = 4;
  localparam int PIN_STATE_LSB = 8;

  // reset values
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [2:0] RST_CLKSEL = 3'h0;

  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // prescaler divide masks: tick when the low bits of the free counter are zero
  localparam logic [9:0] DIV1_MASK = 10'h000;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV32_MASK = 10'h01f;
  localparam logic [9:0] DIV64_MASK = 10'h03f;
  localparam logic [9:0] DIV128_MASK = 10'h07f;
  localparam logic [9:0] DIV256_MASK = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;

  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'b000,
    WAVE_PHASE = 3'b001,
    WAVE_CLEAR_ON_MATCH = 3'b010,
    WAVE_FAST_MAX = 3'b011,
    WAVE_PHASE_CMP = 3'b101,
    WAVE_FAST_CMP = 3'b111
  } wave_mode_t;

  typedef enum logic [1:0] {
    OMODE_OFF = 2'b00,
    OMODE_TOGGLE = 2'b01,
    OMODE_CLEAR = 2'b10,
    OMODE_SET = 2'b11
  } omode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
  } pin_drive_t;

endpackage

/* logic/timer_compare.sv */
// 8-bit timer with two compare channels, waveform modes and APB registers
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module timer_compare #(
  parameter int CHANNELS = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [CHANNELS-1:0] pin_out,
  output logic [CHANNELS-1:0] pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0] wave;
    logic [2:0] clksel;
    logic [CHANNELS-1:0][1:0] omode;
    logic [7:0] cnt;
    logic [CHANNELS-1:0][7:0] cmp;
    logic [CHANNELS-1:0][7:0] cmp_buf;
    logic [CHANNELS-1:0] ostate;
    logic ovf;
    logic [CHANNELS-1:0] mflag;
    logic [CHANNELS-1:0] mpend;
    logic blk;
    logic [9:0] pre;
    logic [CHANNELS-1:0] port_d;
    logic [CHANNELS-1:0] dir;
    logic [CHANNELS-1:0] pin_q;
    logic [CHANNELS-1:0] oe_q;
    logic [31:0] rdata;
  } state_t;

  state_t s_ff;
  state_t nxt_s;

  timer_pkg::apb_req_t req;
  logic wr;
  logic rd_setup;
  logic hit;
  logic tick;
  logic pwm;
  logic clear_on_match_mode;
  logic at_top;
  logic wr_cnt;
  logic wr_force;
  logic [7:0] top_v;
  logic [9:0] div_mask;
  logic [CHANNELS-1:0] match;

  assign req.psel = psel;
  assign req.penable = penable;
  assign req.pwrite = pwrite;
  assign req.paddr = paddr;
  assign req.pwdata = pwdata;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, error on unmapped word
  always_comb begin
    case (req.paddr)
      timer_pkg::OFF_CTRL,
      timer_pkg::OFF_COUNT,
      timer_pkg::OFF_CMP_A,
      timer_pkg::OFF_CMP_B,
      timer_pkg::OFF_FLAGS,
      timer_pkg::OFF_FORCE,
      timer_pkg::OFF_PIN: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign wr = req.psel && req.penable && req.pwrite && hit;
  assign rd_setup = req.psel && !req.penable && !req.pwrite;
  assign wr_cnt = wr && (req.paddr == timer_pkg::OFF_COUNT);
  assign wr_force = wr && (req.paddr == timer_pkg::OFF_FORCE);
  assign pready = 1'b1;
  assign pslverr = req.psel && req.penable && !hit;
  assign prdata = s_ff.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler select to tick
  always_comb begin
    case (s_ff.clksel)
      3'h1: div_mask = timer_pkg::DIV1_MASK;
      3'h2: div_mask = timer_pkg::DIV8_MASK;
      3'h3: div_mask = timer_pkg::DIV32_MASK;
      3'h4: div_mask = timer_pkg::DIV64_MASK;
      3'h5: div_mask = timer_pkg::DIV128_MASK;
      3'h6: div_mask = timer_pkg::DIV256_MASK;
      3'h7: div_mask = timer_pkg::DIV1024_MASK;
      default: div_mask = timer_pkg::DIV1_MASK;
    endcase
  end

  // select zero stops the timer
  assign tick = (s_ff.clksel != 3'h0) && ((s_ff.pre & div_mask) == 10'h000);

  always_comb begin
    case (s_ff.wave)
      timer_pkg::WAVE_FAST_MAX: begin
        pwm = 1'b1;
        clear_on_match_mode = 1'b0;
        top_v = timer_pkg::CNT_MAX;
      end
      timer_pkg::WAVE_FAST_CMP: begin
        pwm = 1'b1;
        clear_on_match_mode = 1'b0;
        top_v = s_ff.cmp[0];
      end
      timer_pkg::WAVE_CLEAR_ON_MATCH: begin
        pwm = 1'b0;
        clear_on_match_mode = 1'b1;
        top_v = s_ff.cmp[0];
      end
      default: begin
        // dual-slope codes are not built; they run as normal mode
        pwm = 1'b0;
        clear_on_match_mode = 1'b0;
        top_v = timer_pkg::CNT_MAX;
      end
    endcase
  end

  assign at_top = (s_ff.cnt == top_v);

  // a count write blocks matches until the next tick has passed
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      assign match[gi] = (s_ff.cnt == s_ff.cmp[gi]) && !s_ff.blk;
      assign pin_out[gi] = s_ff.pin_q[gi];
      assign pin_oe[gi] = s_ff.oe_q[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic act(input logic [1:0] om, input logic cur);
    case (om)
      timer_pkg::OMODE_TOGGLE: act = !cur;
      timer_pkg::OMODE_CLEAR: act = 1'b0;
      timer_pkg::OMODE_SET: act = 1'b1;
      default: act = cur;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input state_t st, input logic [7:0] a);
    read_word = 32'h0;
    case (a)
      timer_pkg::OFF_CTRL: begin
        read_word[timer_pkg::CTRL_WAVE_LSB +: 3] = st.wave;
        read_word[timer_pkg::CTRL_CLKSEL_LSB +: 3] = st.clksel;
        read_word[timer_pkg::CTRL_OMODE_LSB +: 2*CHANNELS] = st.omode;
      end
      timer_pkg::OFF_COUNT: read_word[7:0] = st.cnt;
      timer_pkg::OFF_CMP_A: read_word[7:0] = st.cmp_buf[0];
      timer_pkg::OFF_CMP_B: read_word[7:0] = st.cmp_buf[1];
      timer_pkg::OFF_FLAGS: begin
        read_word[timer_pkg::FLAG_OVF_BIT] = st.ovf;
        read_word[timer_pkg::FLAG_MATCH_LSB +: CHANNELS] = st.mflag;
      end
      timer_pkg::OFF_PIN: begin
        read_word[timer_pkg::PIN_DATA_LSB +: CHANNELS] = st.port_d;
        read_word[timer_pkg::PIN_DIR_LSB +: CHANNELS] = st.dir;
        read_word[timer_pkg::PIN_STATE_LSB +: CHANNELS] = st.ostate;
      end
      default: read_word = 32'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_s = s_ff;
    nxt_s.pre = s_ff.pre + 10'h001;
    if (rd_setup) begin
      nxt_s.rdata = read_word(s_ff, req.paddr);
    end
    // register writes first so that hardware sets below win over clears
    if (wr) begin
      case (req.paddr)
        timer_pkg::OFF_CTRL: begin
          nxt_s.wave = req.pwdata[timer_pkg::CTRL_WAVE_LSB +: 3];
          nxt_s.clksel = req.pwdata[timer_pkg::CTRL_CLKSEL_LSB +: 3];
          // mode takes hold now but only acts at a match, at top in pwm, or at a force outside pwm
          nxt_s.omode = req.pwdata[timer_pkg::CTRL_OMODE_LSB +: 2*CHANNELS];
        end
        timer_pkg::OFF_CMP_A,
        timer_pkg::OFF_CMP_B: begin
          for (int i = 0; i < CHANNELS; i++) begin
            if (req.paddr == (timer_pkg::OFF_CMP_A + 8'(4 * i))) begin
              nxt_s.cmp_buf[i] = req.pwdata[7:0];
              if (!pwm) begin
                nxt_s.cmp[i] = req.pwdata[7:0];
              end
            end
          end
        end
        timer_pkg::OFF_FLAGS: begin
          if (req.pwdata[timer_pkg::FLAG_OVF_BIT]) begin
            nxt_s.ovf = 1'b0;
          end
          nxt_s.mflag = s_ff.mflag & ~req.pwdata[timer_pkg::FLAG_MATCH_LSB +: CHANNELS];
        end
        timer_pkg::OFF_PIN: begin
          nxt_s.port_d = req.pwdata[timer_pkg::PIN_DATA_LSB +: CHANNELS];
          nxt_s.dir = req.pwdata[timer_pkg::PIN_DIR_LSB +: CHANNELS];
        end
        default: begin
        end
      endcase
    end
    // forcing touches only the channel state, never flag or count
    if (wr_force && !pwm) begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (req.pwdata[i]) begin
          nxt_s.ostate[i] = act(s_ff.omode[i], s_ff.ostate[i]);
        end
      end
    end
    if (tick) begin
      nxt_s.blk = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        // match seen now becomes a flag one tick later
        nxt_s.mflag[i] = nxt_s.mflag[i] | s_ff.mpend[i];
        nxt_s.mpend[i] = match[i];
      end
      // counting sequence picks from waveform mode only
      if (pwm) begin
        if (at_top) begin
          nxt_s.cnt = timer_pkg::CNT_BOTTOM;
          nxt_s.ovf = 1'b1;
          nxt_s.cmp = s_ff.cmp_buf;
        end else begin
          nxt_s.cnt = s_ff.cnt + 8'h01;
        end
      end else if (clear_on_match_mode && match[0]) begin
        nxt_s.cnt = timer_pkg::CNT_BOTTOM;
      end else begin
        nxt_s.cnt = s_ff.cnt + 8'h01;
        if (s_ff.cnt == timer_pkg::CNT_MAX) begin
          nxt_s.ovf = 1'b1;
        end
      end
      for (int i = 0; i < CHANNELS; i++) begin
        if (!pwm) begin
          if (match[i]) begin
            nxt_s.ostate[i] = act(s_ff.omode[i], s_ff.ostate[i]);
          end
        end else begin
          case (s_ff.omode[i])
            timer_pkg::OMODE_TOGGLE: begin
              if (match[i]) begin
                nxt_s.ostate[i] = !s_ff.ostate[i];
              end
            end
            timer_pkg::OMODE_CLEAR,
            timer_pkg::OMODE_SET: begin
              // bottom edge wins so compare max gives a steady level
              if (at_top) begin
                nxt_s.ostate[i] = !s_ff.omode[i][0];
              end else if (match[i]) begin
                nxt_s.ostate[i] = s_ff.omode[i][0];
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
    // software count write beats clear and increment
    if (wr_cnt) begin
      nxt_s.cnt = req.pwdata[7:0];
      nxt_s.blk = 1'b1;
    end
    for (int i = 0; i < CHANNELS; i++) begin
      nxt_s.pin_q[i] = (nxt_s.omode[i] != 2'b00) ? nxt_s.ostate[i] : nxt_s.port_d[i];
      nxt_s.oe_q[i] = nxt_s.dir[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.clksel <= timer_pkg::RST_CLKSEL;
      s_ff.cnt <= timer_pkg::RST_COUNT;
      s_ff.cmp <= {CHANNELS{timer_pkg::RST_CMP}};
      s_ff.cmp_buf <= {CHANNELS{timer_pkg::RST_CMP}};
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence top_tick;
    tick && pwm && at_top && !wr_cnt;
  endsequence

  sequence bottom_reached;
    s_ff.cnt == timer_pkg::CNT_BOTTOM && s_ff.ovf;
  endsequence

  chk_pin_override: assert property (
    (s_ff.omode[0] != 2'b00) && $stable(s_ff.omode[0]) && $stable(s_ff.ostate[0])
      |-> pin_out[0] == s_ff.ostate[0])
    else $error("pin not driven from channel state");

  chk_dir_gate: assert property (
    $stable(s_ff.dir) |-> pin_oe == s_ff.dir)
    else $error("pin enable differs from direction");

  chk_mode_zero_hold: assert property (
    tick && (s_ff.omode[0] == 2'b00) && !wr_force |=> $stable(s_ff.ostate[0]))
    else $error("channel state moved with output mode zero");

  chk_normal_wrap: assert property (
    tick && s_ff.wave == 3'b000 && s_ff.cnt == 8'hff && !wr_cnt |=> s_ff.cnt == 8'h00)
    else $error("normal mode did not wrap");

  chk_normal_ovf: assert property (
    tick && !pwm && s_ff.cnt == 8'hff && !clear_on_match_mode |=> s_ff.ovf)
    else $error("overflow not set on wrap");

  chk_ctc_clear: assert property (
    tick && clear_on_match_mode && match[0] && !wr_cnt |=> s_ff.cnt == 8'h00)
    else $error("clear-on-match did not clear count");

  chk_flag_pend: assert property (
    tick && match[0] |=> s_ff.mpend[0])
    else $error("match not held pending for one tick");

  chk_flag_delay: assert property (
    tick && s_ff.mpend[0] |=> s_ff.mflag[0])
    else $error("match flag not set one tick later");

  chk_force_quiet: assert property (
    wr_force && !pwm && !tick && !s_ff.mpend[0] |=> $stable(s_ff.mflag[0]) && $stable(s_ff.cnt))
    else $error("force changed flag or count");

  chk_fast_bottom: assert property (
    top_tick |=> bottom_reached)
    else $error("fast pwm did not restart at bottom with overflow");

  chk_idle_hold: assert property (
    !tick && !wr_cnt |=> $stable(s_ff.cnt))
    else $error("count moved without a tick");

endmodule
